// ===== rtl/sbr_map.svh
`ifndef SBR_MAP_SVH
`define SBR_MAP_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SBR_ADDR_DIV_LOW 12'h000
`define SBR_ADDR_DIV_HIGH 12'h004
`define SBR_ADDR_BAUD_CTRL 12'h008
`define SBR_ADDR_TX_STAT_CTRL 12'h00c
`define SBR_ADDR_IRQ_FLAGS 12'h010
`define SBR_ADDR_IRQ_ENABLES 12'h014
`define SBR_ADDR_STATUS 12'h018
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBR_BIT_WIDE_DIV 3
`define SBR_BIT_HIGH_SPEED 2
`define SBR_BIT_SYNC_MODE 4
`define SBR_BIT_RX_IRQ 5
`define SBR_BIT_TX_IRQ 4
// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define SBR_RST_BYTE 8'h00
`define SBR_BAUD_CTRL_MASK 8'h08
`define SBR_TX_CTRL_MASK 8'h14
`define SBR_IRQ_MASK 8'h30
// ----------------------------------------------------------------
// prescaler end counts, each one less than its factor; tick spacing is factor times (n+1)
// ----------------------------------------------------------------
`define SBR_PRE_64 6'd63
`define SBR_PRE_16 6'd15
`define SBR_PRE_4 6'd3
// ----------------------------------------------------------------
// whole scale factors, used by the period checks
// ----------------------------------------------------------------
`define SBR_FAC_64 7'd64
`define SBR_FAC_16 7'd16
`define SBR_FAC_4 7'd4
`endif

// ===== rtl/sbr_pkg.sv
package sbr_pkg;
  typedef enum logic [1:0] {
    SBR_DIV64,
    SBR_DIV16,
    SBR_DIV4
  } sbr_scale_e;
endpackage : sbr_pkg

// ===== rtl/sbr_prescaler.sv
`timescale 1ns/1ps
`include "sbr_map.svh"
module sbr_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire sbr_pkg::sbr_scale_e scale,
  output logic pre_tick
);
  logic [5:0] pre_reg;
  logic [5:0] top;

  always_comb begin
    case (scale)
      sbr_pkg::SBR_DIV64: top = `SBR_PRE_64;
      sbr_pkg::SBR_DIV16: top = `SBR_PRE_16;
      sbr_pkg::SBR_DIV4: top = `SBR_PRE_4;
      default: top = `SBR_PRE_4;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 6'h00;
    end else if (restart || pre_reg >= top) begin
      pre_reg <= 6'h00;
    end else begin
      pre_reg <= pre_reg + 6'h01;
    end
  end

  assign pre_tick = !restart && (pre_reg >= top);
endmodule : sbr_prescaler

// ===== rtl/sbr_rate_gen.sv
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "sbr_map.svh"
module sbr_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_event,
  input wire logic tx_event,
  output logic baud_tick,
  output logic bit_clk
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic mapped;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `SBR_ADDR_DIV_LOW, `SBR_ADDR_DIV_HIGH, `SBR_ADDR_BAUD_CTRL, `SBR_ADDR_TX_STAT_CTRL,
      `SBR_ADDR_IRQ_FLAGS, `SBR_ADDR_IRQ_ENABLES, `SBR_ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] divisor_low_byte_reg;
  logic [7:0] divisor_high_byte_reg;
  logic [7:0] baud_control_reg;
  logic [7:0] transmit_status_control_reg;
  logic [7:0] peripheral_irq_flags_reg;
  logic [7:0] peripheral_irq_enables_reg;
  logic wr_low;
  logic wr_high;
  assign wr_low = wr && paddr == `SBR_ADDR_DIV_LOW;
  assign wr_high = wr && paddr == `SBR_ADDR_DIV_HIGH;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_low_byte_reg <= `SBR_RST_BYTE;
    end else if (wr_low) begin
      divisor_low_byte_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_high_byte_reg <= `SBR_RST_BYTE;
    end else if (wr_high) begin
      divisor_high_byte_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_control_reg <= `SBR_RST_BYTE;
      transmit_status_control_reg <= `SBR_RST_BYTE;
      peripheral_irq_enables_reg <= `SBR_RST_BYTE;
    end else if (wr) begin
      if (paddr == `SBR_ADDR_BAUD_CTRL) begin
        baud_control_reg <= pwdata[7:0] & `SBR_BAUD_CTRL_MASK;
      end
      if (paddr == `SBR_ADDR_TX_STAT_CTRL) begin
        transmit_status_control_reg <= pwdata[7:0] & `SBR_TX_CTRL_MASK;
      end
      if (paddr == `SBR_ADDR_IRQ_ENABLES) begin
        peripheral_irq_enables_reg <= pwdata[7:0] & `SBR_IRQ_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags: write one to clear, a new event wins
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb begin
    flag_set = 8'h00;
    flag_set[`SBR_BIT_RX_IRQ] = rx_event;
    flag_set[`SBR_BIT_TX_IRQ] = tx_event;
    flag_clr = (wr && paddr == `SBR_ADDR_IRQ_FLAGS) ? (pwdata[7:0] & `SBR_IRQ_MASK) : 8'h00;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_flags_reg <= `SBR_RST_BYTE;
    end else begin
      peripheral_irq_flags_reg <= (peripheral_irq_flags_reg & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  logic wide_divisor_select;
  logic high_speed_select;
  logic sync_mode;
  logic [15:0] rate_divisor;
  sbr_pkg::sbr_scale_e scale;
  assign wide_divisor_select = baud_control_reg[`SBR_BIT_WIDE_DIV];
  assign high_speed_select = transmit_status_control_reg[`SBR_BIT_HIGH_SPEED];
  assign sync_mode = transmit_status_control_reg[`SBR_BIT_SYNC_MODE];
  // high byte only counts with the wide divisor
  assign rate_divisor = wide_divisor_select ? {divisor_high_byte_reg, divisor_low_byte_reg}
      : {8'h00, divisor_low_byte_reg};

  always_comb begin
    if (sync_mode) begin
      scale = sbr_pkg::SBR_DIV4;
    end else if (wide_divisor_select) begin
      scale = high_speed_select ? sbr_pkg::SBR_DIV4 : sbr_pkg::SBR_DIV16;
    end else begin
      scale = high_speed_select ? sbr_pkg::SBR_DIV16 : sbr_pkg::SBR_DIV64;
    end
  end

  // ----------------------------------------------------------------
  // rate counter
  // ----------------------------------------------------------------
  logic restart;
  logic pre_tick;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  // a mode change mid-count would give one odd period, so restart too
  assign restart = wr_low || wr_high || (wr && (paddr == `SBR_ADDR_BAUD_CTRL ||
      paddr == `SBR_ADDR_TX_STAT_CTRL));

  sbr_prescaler sbr_prescaler_inst (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .scale(scale),
    .pre_tick(pre_tick)
  );

  always_comb begin
    cnt_next = cnt_reg;
    if (restart) begin
      cnt_next = 16'h0000;
    end else if (pre_tick) begin
      cnt_next = (cnt_reg >= rate_divisor) ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  logic tick_reg;
  logic bit_clk_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 1'b0;
      bit_clk_reg <= 1'b0;
    end else begin
      tick_reg <= !restart && pre_tick && (cnt_reg >= rate_divisor);
      if (restart) begin
        bit_clk_reg <= 1'b0;
      end else if (pre_tick && cnt_reg >= rate_divisor) begin
        bit_clk_reg <= !bit_clk_reg;
      end
    end
  end
  assign baud_tick = tick_reg;
  assign bit_clk = bit_clk_reg;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SBR_ADDR_DIV_LOW: prdata <= {24'h000000, divisor_low_byte_reg};
        `SBR_ADDR_DIV_HIGH: prdata <= {24'h000000, divisor_high_byte_reg};
        `SBR_ADDR_BAUD_CTRL: prdata <= {24'h000000, baud_control_reg};
        `SBR_ADDR_TX_STAT_CTRL: prdata <= {24'h000000, transmit_status_control_reg};
        `SBR_ADDR_IRQ_FLAGS: prdata <= {24'h000000, peripheral_irq_flags_reg};
        `SBR_ADDR_IRQ_ENABLES: prdata <= {24'h000000, peripheral_irq_enables_reg};
        `SBR_ADDR_STATUS: prdata <= {16'h0000, cnt_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // check helpers: period worked out from the mode bits and divisor bytes alone
  // ----------------------------------------------------------------
  logic [6:0] fac_chk;
  logic [16:0] div_chk;
  logic [23:0] period_chk;
  logic [23:0] gap_reg;
  always_comb begin
    if (sync_mode) begin
      fac_chk = `SBR_FAC_4;
    end else if (wide_divisor_select) begin
      fac_chk = high_speed_select ? `SBR_FAC_4 : `SBR_FAC_16;
    end else begin
      fac_chk = high_speed_select ? `SBR_FAC_16 : `SBR_FAC_64;
    end
    div_chk = (wide_divisor_select ? {1'b0, divisor_high_byte_reg, divisor_low_byte_reg}
        : {9'h000, divisor_low_byte_reg}) + 17'h00001;
    period_chk = {17'h00000, fac_chk} * {7'h00, div_chk};
  end

  // cycles since the last tick or restart; only the checks read it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 24'h000000;
    end else if (restart) begin
      gap_reg <= 24'h000000;
    end else if (baud_tick) begin
      gap_reg <= 24'h000001;
    end else begin
      gap_reg <= gap_reg + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_HIGH_RESET_ZERO: assert property (@(posedge pclk)
      $rose(presetn) |-> divisor_high_byte_reg == 8'h00)
    else $error("high divisor byte not zero after reset");
  AST_HIGH_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
      !wide_divisor_select |-> rate_divisor[15:8] == 8'h00)
    else $error("high byte used without wide divisor");
  AST_HIGH_WRITE_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
      wr_high |=> cnt_reg == 16'h0000 && !baud_tick)
    else $error("counter not restarted by high byte write");
  AST_DIV_CONCAT: assert property (@(posedge pclk) disable iff (!presetn)
      wide_divisor_select |-> rate_divisor == {divisor_high_byte_reg, divisor_low_byte_reg})
    else $error("divisor not high over low");
  AST_ASYNC_SLOW8: assert property (@(posedge pclk) disable iff (!presetn)
      !sync_mode && !wide_divisor_select && !high_speed_select |-> scale == sbr_pkg::SBR_DIV64)
    else $error("wrong scale for async slow 8-bit");
  AST_ASYNC_SLOW16: assert property (@(posedge pclk) disable iff (!presetn)
      !sync_mode && wide_divisor_select && !high_speed_select |-> scale == sbr_pkg::SBR_DIV16)
    else $error("wrong scale for async slow 16-bit");
  AST_SYNC_DIV4: assert property (@(posedge pclk) disable iff (!presetn)
      sync_mode |-> scale == sbr_pkg::SBR_DIV4)
    else $error("wrong scale in sync mode");
  AST_RX_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      rx_event |=> peripheral_irq_flags_reg[`SBR_BIT_RX_IRQ])
    else $error("receive flag not set");
  AST_ASYNC_FAST8: assert property (@(posedge pclk) disable iff (!presetn)
      !sync_mode && !wide_divisor_select && high_speed_select |-> scale == sbr_pkg::SBR_DIV16)
    else $error("wrong scale for async fast 8-bit");
  AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick && scale == sbr_pkg::SBR_DIV4 && rate_divisor == 16'h0000 && !restart
      ##1 !restart[*4] |-> baud_tick)
    else $error("fast tick spacing wrong");
  AST_PERIOD_EXACT: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick |-> gap_reg == period_chk)
    else $error("tick spacing differs from mode formula");
  AST_PERIOD_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
      gap_reg <= period_chk)
    else $error("tick overdue");
  AST_TICK_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick |=> !baud_tick)
    else $error("tick longer than one cycle");
  AST_BITCLK_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick |-> bit_clk != $past(bit_clk))
    else $error("bit clock did not toggle on tick");
  AST_BITCLK_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
      !baud_tick && !$past(restart) |-> $stable(bit_clk))
    else $error("bit clock moved between ticks");
  AST_HIGH_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn)
      wr_high |=> divisor_high_byte_reg == $past(pwdata[7:0]))
    else $error("high divisor byte write lost");
  AST_HIGH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_high |=> $stable(divisor_high_byte_reg))
    else $error("high divisor byte changed without write");
  AST_TX_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      tx_event |=> peripheral_irq_flags_reg[`SBR_BIT_TX_IRQ])
    else $error("transmit flag not set");
  AST_RX_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == `SBR_ADDR_IRQ_FLAGS && pwdata[`SBR_BIT_RX_IRQ] && !rx_event
      |=> !peripheral_irq_flags_reg[`SBR_BIT_RX_IRQ])
    else $error("receive flag not cleared");
  AST_RX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !rx_event && !flag_clr[`SBR_BIT_RX_IRQ] |=> $stable(peripheral_irq_flags_reg[`SBR_BIT_RX_IRQ]))
    else $error("receive flag changed by itself");
  AST_FLAG_OTHERS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (peripheral_irq_flags_reg & ~(`SBR_IRQ_MASK)) == 8'h00)
    else $error("flag outside receive and transmit set");
endmodule : sbr_rate_gen

// ===== tb/sbr_rate_gen_tb_top.sv
`timescale 1ns/1ps
`include "sbr_map.svh"
module sbr_rate_gen_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_event = 1'b0;
  logic tx_event = 1'b0;
  logic baud_tick;
  logic bit_clk;
  logic [31:0] rd;
  logic err;
  logic bc;
  int mismatches = 0;
  int cmp_count = 0;
  int c;
  int f;
  int n;

  always #5 pclk = ~pclk;

  sbr_rate_gen sbr_rate_gen_inst (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_event(rx_event),
    .tx_event(tx_event),
    .baud_tick(baud_tick),
    .bit_clk(bit_clk)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // counts edges up to the one that raised the tick; sampled 1 ns late
  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      #1;
      cnt++;
    end while (baud_tick !== 1'b1 && cnt < 5000);
    if (baud_tick !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask : wait_tick

  // ----------------------------------------------------------------
  // mode table: {wide, sync, high speed}
  // ----------------------------------------------------------------
  logic [2:0] modes [8] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b010, 3'b011, 3'b110, 3'b111};

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 12'(a * 4), 32'h0);
      check(rd, 32'h0000_0000);
    end
    apb(1'b1, `SBR_ADDR_DIV_HIGH, 32'hffff_ffa5);
    apb(1'b0, `SBR_ADDR_DIV_HIGH, 32'h0);
    check(rd, 32'h0000_00a5);
    apb(1'b0, 12'h01c, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `SBR_ADDR_IRQ_ENABLES, 32'hffff_ffff);
    apb(1'b0, `SBR_ADDR_IRQ_ENABLES, 32'h0);
    check(rd, 32'h0000_0030);
    // flags set by a single-cycle event, cleared by writing one
    @(posedge pclk);
    rx_event <= 1'b1;
    @(posedge pclk);
    rx_event <= 1'b0;
    apb(1'b0, `SBR_ADDR_IRQ_FLAGS, 32'h0);
    check(rd, 32'h0000_0020);
    @(posedge pclk);
    tx_event <= 1'b1;
    @(posedge pclk);
    tx_event <= 1'b0;
    apb(1'b0, `SBR_ADDR_IRQ_FLAGS, 32'h0);
    check(rd, 32'h0000_0030);
    apb(1'b1, `SBR_ADDR_IRQ_FLAGS, 32'h0000_0020);
    apb(1'b0, `SBR_ADDR_IRQ_FLAGS, 32'h0);
    check(rd, 32'h0000_0010);
    // high byte of 1 must vanish in the 8-bit modes
    for (int m = 0; m < 8; m++) begin
      f = modes[m][1] ? 4 : (modes[m][2] ? (modes[m][0] ? 4 : 16) : (modes[m][0] ? 16 : 64));
      n = modes[m][2] ? 258 : 2;
      apb(1'b1, `SBR_ADDR_BAUD_CTRL, {28'h0, modes[m][2], 3'h0});
      apb(1'b1, `SBR_ADDR_TX_STAT_CTRL, {27'h0, modes[m][1], 1'b0, modes[m][0], 2'h0});
      apb(1'b1, `SBR_ADDR_DIV_LOW, 32'h0000_0002);
      apb(1'b1, `SBR_ADDR_DIV_HIGH, 32'h0000_0001);
      wait_tick(c);
      check(32'(c), 32'(f * (n + 1)));
      bc = bit_clk;
      wait_tick(c);
      check(32'(c), 32'(f * (n + 1)));
      check({31'h0, bit_clk}, {31'h0, ~bc});
    end
    // smallest divisor: ticks four cycles apart
    apb(1'b1, `SBR_ADDR_DIV_LOW, 32'h0000_0000);
    apb(1'b1, `SBR_ADDR_DIV_HIGH, 32'h0000_0000);
    wait_tick(c);
    check(32'(c), 32'h0000_0004);
    wait_tick(c);
    check(32'(c), 32'h0000_0004);
    final_report();
  end
endmodule : sbr_rate_gen_tb_top
